// ==== floating_logic.v ====
`timescale 1ns/1ps
`include "float_logic_consts.vh"

module floating_logic #(
    parameter SLOPE_W = `SLOPE_W
) (
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    input  wire        ce,
    input  wire        master_power_on_reset_n,
    // host multiplexed bus
    input  wire        ale,
    input  wire [15:0] ad_in,
    output reg  [15:0] ad_out,
    output reg         ad_oe,
    input  wire        bus_read_strobe_n,
    input  wire        bus_write_strobe_n,
    // chip enables
    output reg         ram_ce_n,
    output reg         rom_ce_n,
    output reg         regs_ce_n,
    // converter
    input  wire        comp_in,
    input  wire        meas_trigger,
    input  wire        integ_end,
    output reg         steer_pos,
    output reg         steer_neg,
    // configuration chain
    output reg         cfg_chain_clock,
    output reg         cfg_chain_out,
    input  wire        cfg_chain_return,
    // front panel
    output reg         panel_shift_clock,
    output reg         panel_data_toward,
    input  wire        panel_data_from,
    input  wire        panel_irq_req_n,
    output reg         panel_irq_to_host
);

    ////////////////////////////////////////////////////////////////////////////
    // timing counts

    localparam integer SAMPLE_CYC = `SAMPLE_PERIOD_PS / `CLK_PERIOD_PS;
    localparam integer CFG_HALF_I = `CLK_HZ / (2 * `CFG_RATE_BPS);
    localparam integer PNL_HALF_I = `CLK_HZ / (2 * `PANEL_RATE_BPS);
    localparam [11:0]  CFG_HALF   = CFG_HALF_I[11:0];
    localparam [11:0]  PANEL_HALF = PNL_HALF_I[11:0];
    localparam integer SAMPLE_M1  = SAMPLE_CYC - 1;
    localparam [9:0]   SAMPLE_END = SAMPLE_M1[9:0];

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    wire [`SYNC_W-1:0] pins_s;
    wire [15:0]        ad_s;

    sync_bits #(
        .W    (`SYNC_W),
        .INIT (`SYNC_IDLE)
    ) u_sync_pins (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .d     ({panel_irq_req_n, panel_data_from, cfg_chain_return, integ_end,
                 meas_trigger, comp_in, bus_write_strobe_n, bus_read_strobe_n,
                 ale, master_power_on_reset_n}),
        .q     (pins_s)
    );

    sync_bits #(
        .W    (16),
        .INIT (16'h0000)
    ) u_sync_ad (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .d     (ad_in),
        .q     (ad_s)
    );

    // por pin keeps everything else in reset until it is released
    wire srst_n = rst_n & pins_s[`SY_POR];

    wire ale_s   = pins_s[`SY_ALE];
    wire rd_s    = pins_s[`SY_RD];
    wire wr_s    = pins_s[`SY_WR];
    wire comp_s  = pins_s[`SY_COMP];
    wire trig_s  = pins_s[`SY_TRIG];
    wire end_s   = pins_s[`SY_END];
    wire irq_n_s = pins_s[`SY_IRQ];

    ////////////////////////////////////////////////////////////////////////////
    // edge detection

    reg rd_prev;
    reg wr_prev;
    reg trig_prev;
    reg end_prev;
    reg irq_prev_n;

    always @(posedge clk) begin
        if (!srst_n) begin
            rd_prev    <= 1'b1;
            wr_prev    <= 1'b1;
            trig_prev  <= 1'b0;
            end_prev   <= 1'b0;
            irq_prev_n <= 1'b1;
        end else if (ce) begin
            rd_prev    <= rd_s;
            wr_prev    <= wr_s;
            trig_prev  <= trig_s;
            end_prev   <= end_s;
            irq_prev_n <= irq_n_s;
        end
    end

    wire trig_rise = trig_s & ~trig_prev;
    wire end_rise  = end_s & ~end_prev;
    wire irq_fall  = ~irq_n_s & irq_prev_n;
    wire wr_rise   = wr_s & ~wr_prev;

    ////////////////////////////////////////////////////////////////////////////
    // address latch and decode

    reg [15:0] addr;

    always @(posedge clk) begin
        if (!srst_n) begin
            addr      <= 16'h0000;
            ram_ce_n  <= 1'b1;
            rom_ce_n  <= 1'b1;
            regs_ce_n <= 1'b1;
        end else if (ce && ale_s) begin
            // address is valid on the bus only while the latch enable is high
            addr      <= ad_s;
            ram_ce_n  <= ~(ad_s <= `RAM_TOP);
            regs_ce_n <= ~((ad_s >= `REG_BASE) && (ad_s < `ROM_BASE));
            rom_ce_n  <= ~(ad_s >= `ROM_BASE);
        end
    end

    wire [2:0] reg_idx = addr[2:0];

    ////////////////////////////////////////////////////////////////////////////
    // charge balancing loop

    reg [9:0]         sample_cnt;
    reg [SLOPE_W-1:0] slope_cnt;
    reg [7:0]         slope_count_low;
    reg               comp_level;

    always @(posedge clk) begin
        if (!srst_n) begin
            sample_cnt      <= 10'h000;
            slope_cnt       <= {SLOPE_W{1'b0}};
            slope_count_low <= `BYTE_RESET;
            comp_level      <= 1'b0;
            steer_pos       <= 1'b0;
            steer_neg       <= 1'b0;
        end else if (ce) begin
            // no enable gates the loop: it runs whether or not a trigger came
            if (sample_cnt == SAMPLE_END) begin
                sample_cnt <= 10'h000;
                comp_level <= comp_s;
                // above midpoint pulls down, below pushes up
                steer_neg  <= comp_s;
                steer_pos  <= ~comp_s;
            end else begin
                sample_cnt <= sample_cnt + 10'h001;
            end
            if (trig_rise) begin
                slope_cnt <= {SLOPE_W{1'b0}};
            end else if (sample_cnt == SAMPLE_END && !comp_s) begin
                slope_cnt <= slope_cnt + {{(SLOPE_W-1){1'b0}}, 1'b1};
            end
            if (end_rise) begin
                slope_count_low <= slope_cnt[`SLOPE_LOW_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register writes

    reg  [7:0] config_reg;
    reg  [7:0] tx_byte;
    reg  [7:0] wdata;
    reg        ser_start;
    reg        done_flag;
    reg        irq_flag;
    wire       sh_busy;
    wire       sh_done;
    wire [7:0] rx_byte;
    wire       wr_hit   = wr_rise & ~regs_ce_n;
    wire       st_write = wr_hit && reg_idx == `REG_STATUS;
    wire       panel_sel = config_reg[`CFG_DEST_BIT];

    always @(posedge clk) begin
        if (!srst_n) begin
            config_reg <= `CONFIG_RESET;
            tx_byte    <= `BYTE_RESET;
            wdata      <= `BYTE_RESET;
            ser_start  <= 1'b0;
        end else if (ce) begin
            ser_start <= 1'b0;
            // data is held while the strobe is low, used at its rising edge
            if (!wr_s) begin
                wdata <= ad_s[7:0];
            end
            if (wr_hit && reg_idx == `REG_CONFIG) begin
                config_reg <= wdata;
            end
            // a write while a byte is still shifting is dropped
            if (wr_hit && reg_idx == `REG_SERIAL && !sh_busy) begin
                tx_byte   <= wdata;
                ser_start <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status flags, write one to clear, hardware set wins

    always @(posedge clk) begin
        if (!srst_n) begin
            done_flag         <= 1'b0;
            irq_flag          <= 1'b0;
            panel_irq_to_host <= 1'b0;
        end else if (ce) begin
            if (sh_done) begin
                done_flag <= 1'b1;
            end else if (st_write && wdata[`ST_DONE_BIT]) begin
                done_flag <= 1'b0;
            end
            if (irq_fall) begin
                irq_flag <= 1'b1;
            end else if (st_write && wdata[`ST_IRQ_BIT]) begin
                irq_flag <= 1'b0;
            end
            panel_irq_to_host <= irq_fall | (irq_flag & ~(st_write & wdata[`ST_IRQ_BIT]));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register reads

    reg [7:0] rdata;

    always @* begin
        rdata = 8'h00;
        case (reg_idx)
            `REG_CONFIG: rdata = config_reg;
            `REG_COUNT:  rdata = slope_count_low;
            `REG_SERIAL: rdata = rx_byte;
            `REG_STATUS: begin
                rdata[`ST_DONE_BIT] = done_flag;
                rdata[`ST_BUSY_BIT] = sh_busy;
                rdata[`ST_IRQ_BIT]  = irq_flag;
                rdata[`ST_COMP_BIT] = comp_level;
            end
            default:     rdata = 8'h00;
        endcase
    end

    always @(posedge clk) begin
        if (!srst_n) begin
            ad_out <= 16'h0000;
            ad_oe  <= 1'b0;
        end else if (ce) begin
            ad_oe  <= ~regs_ce_n & ~rd_s;
            ad_out <= {8'h00, rdata};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // serial shifter and routing

    reg  dest_panel;
    wire sh_sclk;
    wire sh_sdo;
    wire sh_sdi = dest_panel ? pins_s[`SY_PANEL_FROM] : pins_s[`SY_CFG_RET];

    serial_shifter #(
        .CFG_HALF   (CFG_HALF),
        .PANEL_HALF (PANEL_HALF)
    ) u_shifter (
        .clk        (clk),
        .rst_n      (srst_n),
        .ce         (ce),
        .start      (ser_start),
        .panel_mode (panel_sel),
        .tx_byte    (tx_byte),
        .sdi        (sh_sdi),
        .sclk       (sh_sclk),
        .sdo        (sh_sdo),
        .busy       (sh_busy),
        .done       (sh_done),
        .rx_byte    (rx_byte)
    );

    // destination is frozen for the whole byte so a config write mid-transfer
    // cannot split it across two targets
    always @(posedge clk) begin
        if (!srst_n) begin
            dest_panel        <= 1'b0;
            cfg_chain_clock   <= 1'b0;
            cfg_chain_out     <= 1'b0;
            panel_shift_clock <= 1'b0;
            panel_data_toward <= 1'b0;
        end else if (ce) begin
            if (ser_start) begin
                dest_panel <= panel_sel;
            end
            // chain only shifts here; its outputs move on the host strobe alone
            cfg_chain_clock   <= sh_sclk & ~dest_panel;
            cfg_chain_out     <= sh_sdo & ~dest_panel;
            // every panel byte clocks one byte back in
            panel_shift_clock <= sh_sclk & dest_panel;
            panel_data_toward <= sh_sdo & dest_panel;
        end
    end

endmodule

// ==== float_logic_consts.vh ====
`ifndef FLOAT_LOGIC_CONSTS_VH
`define FLOAT_LOGIC_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// clock and timing
`define CLK_HZ           200000000
`define CLK_PERIOD_PS    5000
`define SAMPLE_PERIOD_PS 2660000
`define CFG_RATE_BPS     1500000
`define PANEL_RATE_BPS   93750

////////////////////////////////////////////////////////////////////////////////
// memory map
`define RAM_TOP          16'h1ff7
`define REG_BASE         16'h1ff8
`define ROM_BASE         16'h2000

////////////////////////////////////////////////////////////////////////////////
// register indices within the register window
`define REG_CONFIG       3'h0
`define REG_COUNT        3'h1
`define REG_SERIAL       3'h2
`define REG_STATUS       3'h3

////////////////////////////////////////////////////////////////////////////////
// fields
`define CFG_DEST_BIT     0
`define ST_DONE_BIT      0
`define ST_BUSY_BIT      1
`define ST_IRQ_BIT       2
`define ST_COMP_BIT      3
`define CONFIG_RESET     8'h00
`define BYTE_RESET       8'h00
`define SLOPE_W          24
`define SLOPE_LOW_W      8
`define SER_BITS         4'h8

////////////////////////////////////////////////////////////////////////////////
// synchroniser bit positions and idle levels
`define SYNC_W           10
`define SY_POR           0
`define SY_ALE           1
`define SY_RD            2
`define SY_WR            3
`define SY_COMP          4
`define SY_TRIG          5
`define SY_END           6
`define SY_CFG_RET       7
`define SY_PANEL_FROM    8
`define SY_IRQ           9
`define SYNC_IDLE        10'h20c

`endif

// ==== sync_bits.v ====
`timescale 1ns/1ps

// two-flop synchroniser; the first stage feeds only the second
module sync_bits #(
    parameter         W    = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
) (
    // clock and reset
    input  wire         clk,
    input  wire         rst_n,
    input  wire         ce,
    // data
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);

    reg [W-1:0] meta;

    always @(posedge clk) begin
        if (!rst_n) begin
            meta <= INIT;
            q    <= INIT;
        end else if (ce) begin
            meta <= d;
            q    <= meta;
        end
    end

endmodule

// ==== serial_shifter.v ====
`timescale 1ns/1ps
`include "float_logic_consts.vh"

// eight-bit full-duplex shifter, msb first, clock idles low
module serial_shifter #(
    parameter [11:0] CFG_HALF   = 12'd66,
    parameter [11:0] PANEL_HALF = 12'd1066
) (
    // clock and reset
    input  wire       clk,
    input  wire       rst_n,
    input  wire       ce,
    // control
    input  wire       start,
    input  wire       panel_mode,
    input  wire [7:0] tx_byte,
    // line
    input  wire       sdi,
    output reg        sclk,
    output reg        sdo,
    // result
    output reg        busy,
    output reg        done,
    output reg  [7:0] rx_byte
);

    reg [7:0]  shreg;
    reg [3:0]  bits;
    reg [11:0] phase;
    reg [11:0] half;

    always @(posedge clk) begin
        if (!rst_n) begin
            sclk    <= 1'b0;
            sdo     <= 1'b0;
            busy    <= 1'b0;
            done    <= 1'b0;
            rx_byte <= `BYTE_RESET;
            shreg   <= `BYTE_RESET;
            bits    <= 4'h0;
            phase   <= 12'h000;
            half    <= CFG_HALF;
        end else if (ce) begin
            done <= 1'b0;
            if (!busy) begin
                if (start) begin
                    busy  <= 1'b1;
                    half  <= panel_mode ? PANEL_HALF : CFG_HALF;
                    shreg <= tx_byte;
                    sdo   <= tx_byte[7];
                    bits  <= 4'h0;
                    phase <= 12'h001;
                end
            end else if (phase < half) begin
                phase <= phase + 12'h001;
            end else begin
                phase <= 12'h001;
                sclk  <= ~sclk;
                if (sclk) begin
                    // capture on the falling edge so the far end has a full high half
                    shreg <= {shreg[6:0], sdi};
                    sdo   <= shreg[6];
                    bits  <= bits + 4'h1;
                    if (bits == `SER_BITS - 4'h1) begin
                        busy    <= 1'b0;
                        done    <= 1'b1;
                        rx_byte <= {shreg[6:0], sdi};
                        sdo     <= 1'b0;
                    end
                end
            end
        end
    end

endmodule

// ==== serial_far_end.sv ====
`timescale 1ns/1ps

// far end of one serial route: chain of n bits or the panel's byte register
module serial_far_end #(
    parameter N = 8
) (
    // line
    input  wire         sclk,
    input  wire         din,
    output wire         dout,
    // control
    input  wire         load,
    input  wire [N-1:0] load_val,
    input  wire         strobe,
    // observed state
    output reg  [N-1:0] sr,
    output reg  [N-1:0] par_out,
    output reg  [7:0]   nbits
);
    reg held;

    initial begin
        sr      = {N{1'b0}};
        par_out = {N{1'b0}};
        nbits   = 8'h00;
        held    = 1'b0;
    end

    always @(posedge load) begin
        sr <= load_val;
    end

    // sample on the rise, move on the fall, so the device's fall sample sees a settled bit
    always @(posedge sclk) begin
        held  <= din;
        nbits <= nbits + 8'h01;
    end

    always @(negedge sclk) begin
        sr <= #1 {sr[N-2:0], held};
    end

    assign dout = sr[N-1];

    // parallel outputs move only on the strobe
    always @(posedge strobe) begin
        par_out <= sr;
    end
endmodule

// ==== floating_logic_monitor.sv ====
`timescale 1ns/1ps

module floating_logic_monitor (
    // clock and reset
    input wire        clk,
    input wire        rst_n,
    input wire        master_power_on_reset_n,
    // bus
    input wire        ale,
    input wire [15:0] ad_in,
    input wire [15:0] ad_out,
    input wire        ad_oe,
    input wire        bus_read_strobe_n,
    input wire        ram_ce_n,
    input wire        rom_ce_n,
    input wire        regs_ce_n,
    // converter, serial, interrupt
    input wire        comp_in,
    input wire        steer_pos,
    input wire        steer_neg,
    input wire        cfg_chain_clock,
    input wire        panel_shift_clock,
    input wire        panel_irq_req_n,
    input wire        panel_irq_to_host
);
    reg [11:0] cfg_hi;
    reg [11:0] pan_hi;
    reg [9:0]  since;
    reg        seen;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n || !master_power_on_reset_n);

    ////////////////////////////////////////////////////////////////////////////
    // helper counters; a drop of steering to 0/0 (reset) forgets the grid
    always @(posedge clk) begin
        if (!rst_n || !master_power_on_reset_n) begin
            cfg_hi <= 12'h000;
            pan_hi <= 12'h000;
            since  <= 10'h000;
            seen   <= 1'b0;
        end else begin
            cfg_hi <= cfg_chain_clock ? cfg_hi + 12'h001 : 12'h000;
            pan_hi <= panel_shift_clock ? pan_hi + 12'h001 : 12'h000;
            if ($changed({steer_pos, steer_neg})) begin
                since <= 10'h001;
                seen  <= steer_pos || steer_neg;
            end else begin
                since <= (since == 10'h214) ? 10'h001 : since + 10'h001;
            end
        end
    end

    sequence s_ale_in(logic [15:0] lo, logic [15:0] hi);
        (ale && ad_in >= lo && ad_in <= hi)[*5];
    endsequence

    sequence s_reg_read;
        (!regs_ce_n && !bus_read_strobe_n)[*5];
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    a_ram_select: assert property (s_ale_in(16'h0000, 16'h1ff7) |->
        !ram_ce_n && rom_ce_n && regs_ce_n) else $error("ram enable wrong");
    a_regs_select: assert property (s_ale_in(16'h1ff8, 16'h1fff) |->
        ram_ce_n && rom_ce_n && !regs_ce_n) else $error("register enable wrong");
    a_rom_select: assert property (s_ale_in(16'h2000, 16'hffff) |->
        ram_ce_n && !rom_ce_n && regs_ce_n) else $error("rom enable wrong");
    a_read_drive: assert property (s_reg_read |-> ad_oe)
        else $error("register read not driven");
    a_drive_scope: assert property (ad_oe |-> !regs_ce_n && ad_out[15:8] == 8'h00)
        else $error("bus driven outside register read");
    a_steer_excl: assert property (!(steer_pos && steer_neg))
        else $error("both steering outputs high");
    a_steer_dir: assert property ($rose(steer_neg) |->
        $past(comp_in, 2) || $past(comp_in, 3) || $past(comp_in, 4) || $past(comp_in, 5))
        else $error("negative steering without high comparator");
    a_steer_grid: assert property ($changed({steer_pos, steer_neg}) && seen &&
        (steer_pos || steer_neg) |-> since == 10'h214) else $error("steering off sample grid");
    a_steer_runs: assert property ($rose(rst_n) |-> ##[1:600] (steer_pos ^ steer_neg))
        else $error("steering loop not running");
    a_one_dest: assert property (!(cfg_chain_clock && panel_shift_clock))
        else $error("both serial clocks active");
    a_cfg_rate: assert property ($fell(cfg_chain_clock) |-> cfg_hi == 12'h042)
        else $error("chain clock high time wrong");
    a_panel_rate: assert property ($fell(panel_shift_clock) |-> pan_hi == 12'h42a)
        else $error("panel clock high time wrong");
    a_irq_flag: assert property ($fell(panel_irq_req_n) |-> ##[1:8] panel_irq_to_host)
        else $error("panel request not flagged");
endmodule

// ==== floating_logic_bench.sv ====
`timescale 1ns/1ps

module floating_logic_bench;
    reg         clk, rst_n, ce, master_power_on_reset_n, ale;
    reg         bus_read_strobe_n, bus_write_strobe_n, comp_in, meas_trigger, integ_end;
    reg         panel_irq_req_n, load_cfg, load_pan, cfg_output_strobe;
    reg  [15:0] ad_in;
    reg  [47:0] cfg_seed;
    reg  [7:0]  pan_seed, q;
    wire [15:0] ad_out;
    wire        ad_oe, ram_ce_n, rom_ce_n, regs_ce_n, steer_pos, steer_neg;
    wire        cfg_chain_clock, cfg_chain_out, cfg_chain_return;
    wire        panel_shift_clock, panel_data_toward, panel_data_from, panel_irq_to_host;
    wire [47:0] chain_sr, chain_par;
    wire [7:0]  pan_sr, cfg_bits, pan_bits;
    integer     n_mismatch, n_tests;

    floating_logic dut (.clk, .rst_n, .ce, .master_power_on_reset_n, .ale, .ad_in, .ad_out,
        .ad_oe, .bus_read_strobe_n, .bus_write_strobe_n, .ram_ce_n, .rom_ce_n, .regs_ce_n,
        .comp_in, .meas_trigger, .integ_end, .steer_pos, .steer_neg, .cfg_chain_clock,
        .cfg_chain_out, .cfg_chain_return, .panel_shift_clock, .panel_data_toward,
        .panel_data_from, .panel_irq_req_n, .panel_irq_to_host);

    serial_far_end #(.N(48)) chain (.sclk(cfg_chain_clock), .din(cfg_chain_out),
        .dout(cfg_chain_return), .load(load_cfg), .load_val(cfg_seed),
        .strobe(cfg_output_strobe), .sr(chain_sr), .par_out(chain_par), .nbits(cfg_bits));
    serial_far_end #(.N(8)) panel (.sclk(panel_shift_clock), .din(panel_data_toward),
        .dout(panel_data_from), .load(load_pan), .load_val(pan_seed), .strobe(1'b0),
        .sr(pan_sr), .par_out(), .nbits(pan_bits));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task final_report;
        begin
            $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
            if (n_mismatch == 0 && n_tests > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    task check(input [7:0] got, input [7:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("mismatch at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // host drives the address for the whole latch-enable phase
    task addr_phase(input [15:0] a);
        begin
            @(posedge clk);
            ale   <= 1'b1;
            ad_in <= a;
            repeat (6) @(posedge clk);
            ale <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask

    task bus_wr(input [15:0] a, input [7:0] d);
        begin
            addr_phase(a);
            ad_in              <= {8'h00, d};
            bus_write_strobe_n <= 1'b0;
            repeat (5) @(posedge clk);
            bus_write_strobe_n <= 1'b1;
            repeat (5) @(posedge clk);
        end
    endtask

    task rd_check(input [15:0] a, input [7:0] m, input [7:0] exp);
        begin
            addr_phase(a);
            bus_read_strobe_n <= 1'b0;
            repeat (6) @(posedge clk);
            #1 q = ad_out[7:0];
            @(posedge clk);
            bus_read_strobe_n <= 1'b1;
            repeat (5) @(posedge clk);
            check(q & m, exp);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task t_decode;
        reg [95:0] list;
        reg [15:0] a;
        integer    i;
        begin
            list = {16'h0000, 16'h1ff7, 16'h1ff8, 16'h1fff, 16'h2000, 16'hffff};
            for (i = 0; i < 6; i = i + 1) begin
                a = list[16*i +: 16];
                addr_phase(a);
                check({5'h00, ram_ce_n, rom_ce_n, regs_ce_n}, {5'h00, a > 16'h1ff7,
                    a < 16'h2000, a < 16'h1ff8 || a > 16'h1fff});
            end
            $display("test decode done");
        end
    endtask

    task t_regs;
        begin
            rd_check(16'h1ffb, 8'h07, 8'h00);
            bus_wr(16'h1ff8, 8'h01);
            rd_check(16'h1ff8, 8'h01, 8'h01);
            bus_wr(16'h1ffc, 8'hff);
            rd_check(16'h1ffc, 8'hff, 8'h00);
            $display("test registers done");
        end
    endtask

    task t_slope;
        integer n;
        begin
            comp_in <= 1'b1;
            for (n = 0; n < 1200 && steer_neg !== 1'b1; n = n + 1) @(posedge clk);
            check({7'h00, steer_neg}, 8'h01);
            comp_in <= 1'b0;
            for (n = 0; n < 600 && steer_pos !== 1'b1; n = n + 1) @(posedge clk);
            check({7'h00, steer_pos}, 8'h01);
            // land trigger and end midway between samples: exactly five in between
            repeat (266) @(posedge clk);
            meas_trigger <= 1'b1;
            repeat (2660) @(posedge clk);
            integ_end <= 1'b1;
            repeat (10) @(posedge clk);
            meas_trigger <= 1'b0;
            integ_end    <= 1'b0;
            rd_check(16'h1ff9, 8'hff, 8'h05);
            rd_check(16'h1ffb, 8'h08, 8'h00);
            $display("test slope done");
        end
    endtask

    task t_chain;
        begin
            load_cfg <= 1'b1;
            @(posedge clk);
            load_cfg <= 1'b0;
            bus_wr(16'h1ff8, 8'h00);
            bus_wr(16'h1ffa, 8'ha5);
            bus_wr(16'h1ffa, 8'hff);
            repeat (16 * 66 + 40) @(posedge clk);
            check(chain_sr[7:0], 8'ha5);
            check(cfg_bits, 8'h08);
            check(pan_bits, 8'h00);
            check(chain_par[7:0], 8'h00);
            rd_check(16'h1ffb, 8'h03, 8'h01);
            rd_check(16'h1ffa, 8'hff, cfg_seed[47:40]);
            bus_wr(16'h1ffb, 8'h01);
            rd_check(16'h1ffb, 8'h01, 8'h00);
            cfg_output_strobe <= 1'b1;
            @(posedge clk);
            cfg_output_strobe <= 1'b0;
            @(posedge clk);
            check(chain_par[7:0], 8'ha5);
            $display("test chain done");
        end
    endtask

    task t_panel;
        begin
            load_pan <= 1'b1;
            @(posedge clk);
            load_pan <= 1'b0;
            bus_wr(16'h1ff8, 8'h01);
            bus_wr(16'h1ffa, 8'hc3);
            repeat (16 * 1066 + 40) @(posedge clk);
            check(pan_sr, 8'hc3);
            check(pan_bits, 8'h08);
            check(cfg_bits, 8'h08);
            rd_check(16'h1ffa, 8'hff, pan_seed);
            panel_irq_req_n <= 1'b0;
            repeat (10) @(posedge clk);
            check({7'h00, panel_irq_to_host}, 8'h01);
            rd_check(16'h1ffb, 8'h04, 8'h04);
            panel_irq_req_n <= 1'b1;
            bus_wr(16'h1ffb, 8'h04);
            rd_check(16'h1ffb, 8'h04, 8'h00);
            check({7'h00, panel_irq_to_host}, 8'h00);
            $display("test panel done");
        end
    endtask

    task t_por;
        begin
            master_power_on_reset_n <= 1'b0;
            repeat (5) @(posedge clk);
            master_power_on_reset_n <= 1'b1;
            repeat (8) @(posedge clk);
            check({5'h00, ram_ce_n, rom_ce_n, regs_ce_n}, 8'h07);
            rd_check(16'h1ff8, 8'h01, 8'h00);
            $display("test master reset done");
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        master_power_on_reset_n = 1'b1;
        ale = 1'b0;
        ad_in = 16'h0000;
        bus_read_strobe_n = 1'b1;
        bus_write_strobe_n = 1'b1;
        comp_in = 1'b0;
        meas_trigger = 1'b0;
        integ_end = 1'b0;
        panel_irq_req_n = 1'b1;
        load_cfg = 1'b0;
        load_pan = 1'b0;
        cfg_output_strobe = 1'b0;
        cfg_seed = 48'h9c12_3456_78ab;
        pan_seed = 8'h3c;
        n_mismatch = 0;
        n_tests = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        t_decode;
        t_regs;
        t_slope;
        t_chain;
        t_panel;
        t_por;
        final_report;
    end

    // whole run is about 23k cycles
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch = n_mismatch + 1;
        $display("mismatch at %0t: watchdog expired", $time);
        final_report;
    end
endmodule

bind floating_logic floating_logic_monitor mon (.clk, .rst_n, .master_power_on_reset_n, .ale,
    .ad_in, .ad_out, .ad_oe, .bus_read_strobe_n, .ram_ce_n, .rom_ce_n, .regs_ce_n, .comp_in,
    .steer_pos, .steer_neg, .cfg_chain_clock, .panel_shift_clock, .panel_irq_req_n,
    .panel_irq_to_host);
